//--- design/dbgc_map.svh
// register offsets, field positions and reset values of the digital i/o glue
`ifndef DBGC_MAP_SVH
`define DBGC_MAP_SVH
`define DBGC_OFF_CFG0 4'h3
`define DBGC_OFF_CFG1 4'h7
`define DBGC_OFF_GATE0 4'h8
`define DBGC_OFF_GATE1 4'h9
`define DBGC_OFF_COSEN 4'hB
`define DBGC_OFF_CLR 4'hF
`define DBGC_IDX_CFG 2'h3
`define DBGC_ADDR_HI 3
`define DBGC_ADDR_GRP 2
`define DBGC_ADDR_GATE_GRP 0
`define DBGC_B_MODESET 7
`define DBGC_B_DIR_A 4
`define DBGC_B_DIR_CHI 3
`define DBGC_B_DIR_B 1
`define DBGC_B_DIR_CLO 0
`define DBGC_PORT_W 8
`define DBGC_NIB_W 4
`define DBGC_NPORT 3
`define DBGC_NGRP 2
`define DBGC_COS_W 6
`define DBGC_PC3_LINE 19
`define DBGC_RST_DIR 4'hF
`define DBGC_RST_MASK 6'h3F
`define DBGC_RST_BYTE 8'h00
`define DBGC_RST_LINES 24'h000000
`endif

//--- design/dbgc_pkg.sv
// types and bus decode shared by the digital i/o glue
package dbgc_pkg;
  `include "dbgc_map.svh"
  typedef logic [7:0] dbgc_byte_t;
  typedef logic [23:0] dbgc_lines_t;
  typedef enum logic [2:0] {
    ACC_PORT,
    ACC_CFG,
    ACC_GATE,
    ACC_COSEN,
    ACC_CLR,
    ACC_UNMAPPED
  } dbgc_acc_e;

  function automatic dbgc_acc_e dbgc_decode(input logic [3:0] a);
    dbgc_acc_e r;
    r = ACC_UNMAPPED;
    if (!a[`DBGC_ADDR_HI]) begin
      r = (a[1:0] == `DBGC_IDX_CFG) ? ACC_CFG : ACC_PORT;
    end else begin
      case (a)
        `DBGC_OFF_GATE0, `DBGC_OFF_GATE1: r = ACC_GATE;
        `DBGC_OFF_COSEN: r = ACC_COSEN;
        `DBGC_OFF_CLR: r = ACC_CLR;
        default: r = ACC_UNMAPPED;
      endcase
    end
    return r;
  endfunction : dbgc_decode

  function automatic logic dbgc_group(input logic [3:0] a);
    return a[`DBGC_ADDR_HI] ? a[`DBGC_ADDR_GATE_GRP] : a[`DBGC_ADDR_GRP];
  endfunction : dbgc_group
endpackage : dbgc_pkg

//--- design/dbgc_port_group.sv
// one 24-line parallel port group with its output latches and buffer gate
`timescale 1ns/100ps
`include "dbgc_map.svh"
module dbgc_port_group
  import dbgc_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  input logic tristate_jumper_position,
  input logic wr_data_en,
  input logic wr_cfg_en,
  input logic wr_gate_en,
  input logic [1:0] wr_idx,
  input dbgc_byte_t wdata,
  input dbgc_lines_t pin_in,
  output dbgc_lines_t pin_out_r,
  output dbgc_lines_t pin_oe_r,
  output dbgc_byte_t rd_val
);
  // dir bits: [3] port a, [2] c upper nybble, [1] port b, [0] c lower nybble; 1 = input
  logic [3:0] dir_r, dir_nxt;
  logic buf_off_r, buf_off_nxt;
  dbgc_lines_t latch_nxt, oe_nxt, out_mask, out_mask_nxt, rd_lines;

  function automatic dbgc_lines_t dbgc_mask(input logic [3:0] d);
    return {{`DBGC_NIB_W{~d[2]}}, {`DBGC_NIB_W{~d[0]}}, {`DBGC_PORT_W{~d[1]}},
            {`DBGC_PORT_W{~d[3]}}};
  endfunction : dbgc_mask

  always_comb begin
    dir_nxt = dir_r;
    buf_off_nxt = buf_off_r;
    latch_nxt = pin_out_r;
    if (wr_cfg_en && wdata[`DBGC_B_MODESET]) begin
      // mode bits 6,5,2 must be zero; only mode 0 exists here
      dir_nxt = {wdata[`DBGC_B_DIR_A], wdata[`DBGC_B_DIR_CHI], wdata[`DBGC_B_DIR_B],
                 wdata[`DBGC_B_DIR_CLO]};
      latch_nxt = `DBGC_RST_LINES;
      buf_off_nxt = 1'b1;
    end else if (wr_cfg_en) begin
      buf_off_nxt = 1'b0;
    end else if (wr_gate_en) begin
      buf_off_nxt = wdata[`DBGC_B_MODESET];
    end else if (wr_data_en) begin
      latch_nxt[wr_idx*`DBGC_PORT_W +: `DBGC_PORT_W] = wdata;
    end
    out_mask_nxt = dbgc_mask(dir_nxt);
    // jumper only matters in the gating: the latched gate state is kept either way
    oe_nxt = (buf_off_nxt && tristate_jumper_position) ? `DBGC_RST_LINES
             : out_mask_nxt;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_r <= `DBGC_RST_DIR;
      buf_off_r <= 1'b1;
      pin_out_r <= `DBGC_RST_LINES;
      pin_oe_r <= `DBGC_RST_LINES;
    end else begin
      dir_r <= dir_nxt;
      buf_off_r <= buf_off_nxt;
      pin_out_r <= latch_nxt;
      pin_oe_r <= oe_nxt;
    end
  end

  // reads see the pins on input lines and the latch on output lines
  assign out_mask = dbgc_mask(dir_r);
  assign rd_lines = (pin_in & ~out_mask) | (pin_out_r & out_mask);
  assign rd_val = rd_lines[wr_idx*`DBGC_PORT_W +: `DBGC_PORT_W];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CFG_CLEARS: assert property (
    (wr_cfg_en && wdata[`DBGC_B_MODESET] && tristate_jumper_position)
      |=> (pin_out_r == `DBGC_RST_LINES) && (pin_oe_r == `DBGC_RST_LINES))
    else $error("mode set did not clear latches and gate buffers");
  AST_CFG_LOW_KEEPS_DIR: assert property (
    (wr_cfg_en && !wdata[`DBGC_B_MODESET]) |=> $stable(dir_r) && $stable(pin_out_r))
    else $error("control byte with bit 7 low changed direction or latches");
  AST_GATE_KEEPS_LATCH: assert property (
    wr_gate_en |=> $stable(pin_out_r) && $stable(dir_r))
    else $error("gate write disturbed latches or direction");
  AST_GATE_ENABLE: assert property (
    (wr_gate_en && !wdata[`DBGC_B_MODESET]) |=> (pin_oe_r == out_mask))
    else $error("gate write with bit 7 low did not enable buffers");
  AST_ALWAYS_ON: assert property (
    !tristate_jumper_position |-> ##1 (pin_oe_r == out_mask))
    else $error("buffers gated in always-on jumper position");
  AST_RESET_INPUTS: assert property (
    $rose(rst_n) |-> (pin_oe_r == `DBGC_RST_LINES) && (dir_r == `DBGC_RST_DIR))
    else $error("lines not inputs after reset");
  COV_MODE_SET: cover property (wr_cfg_en && wdata[`DBGC_B_MODESET]);
  COV_REENABLE: cover property (
    (wr_cfg_en && wdata[`DBGC_B_MODESET]) ##[1:20] (wr_gate_en && !wdata[`DBGC_B_MODESET]));
endmodule : dbgc_port_group

//--- design/dbgc_top.sv
// host-bus glue for two 24-line port groups: buffer gating and change-of-state interrupt
// What this block does
// - control byte bit7 mode set, direction bits
// - mode set clears latches, disables buffers
// - group config at offsets 3 and 7
// - gate writes at 8 and 9, latches kept
// - gate bit7 low enables, high disables
// - all interrupt sources masked after reset
// - offset 0xB enable bits per port
// - enable bit one masks, zero enables
// - any access to 0xB unmasks line-three interrupt
// - interrupt latched until explicitly cleared
// - any write to 0xF clears latch unless a new event arrives that cycle
// - port c line three is user interrupt
// - bit7 low control reaches buffer gate only
// - always-on jumper keeps buffers enabled
// - reset leaves all lines input, receiving
`timescale 1ns/100ps
`include "dbgc_map.svh"
module dbgc_top
  import dbgc_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  input logic [3:0] io_addr,
  input logic io_wr,
  input logic io_rd,
  input dbgc_byte_t io_wdata,
  output dbgc_byte_t io_rdata_r,
  input logic tristate_jumper_position,
  input dbgc_lines_t g0_pin_in,
  output dbgc_lines_t g0_pin_out_r,
  output dbgc_lines_t g0_pin_oe_r,
  input dbgc_lines_t g1_pin_in,
  output dbgc_lines_t g1_pin_out_r,
  output dbgc_lines_t g1_pin_oe_r,
  output logic irq_r
);
  dbgc_acc_e wr_acc, rd_acc;
  logic wr_grp, rd_grp;
  dbgc_lines_t pin_in [`DBGC_NGRP];
  dbgc_lines_t pin_out [`DBGC_NGRP];
  dbgc_lines_t pin_oe [`DBGC_NGRP];
  dbgc_byte_t rd_val [`DBGC_NGRP];
  dbgc_lines_t prev_r [`DBGC_NGRP];
  dbgc_lines_t prev_nxt [`DBGC_NGRP];
  logic [`DBGC_COS_W-1:0] cos_mask_r, cos_mask_nxt;
  logic [`DBGC_COS_W-1:0] port_chg, cos_hit;
  logic [`DBGC_NGRP-1:0] pc3_rise;
  logic user_en_r, user_en_nxt;
  logic user_hit, clr_wr, cosen_acc;
  logic irq_nxt;
  dbgc_byte_t rdata_nxt;

  assign wr_acc = dbgc_decode(io_addr);
  assign rd_acc = dbgc_decode(io_addr);
  assign wr_grp = dbgc_group(io_addr);
  assign rd_grp = dbgc_group(io_addr);
  assign pin_in[0] = g0_pin_in;
  assign pin_in[1] = g1_pin_in;
  assign g0_pin_out_r = pin_out[0];
  assign g1_pin_out_r = pin_out[1];
  assign g0_pin_oe_r = pin_oe[0];
  assign g1_pin_oe_r = pin_oe[1];

  genvar g, p;
  generate
    for (g = 0; g < `DBGC_NGRP; g++) begin : gen_grp
      logic sel;
      assign sel = (wr_grp == 1'(g));
      dbgc_port_group u_grp (
        .mclk(mclk),
        .rst_n(rst_n),
        .tristate_jumper_position(tristate_jumper_position),
        .wr_data_en(io_wr && sel && (wr_acc == ACC_PORT)),
        .wr_cfg_en(io_wr && sel && (wr_acc == ACC_CFG)),
        .wr_gate_en(io_wr && sel && (wr_acc == ACC_GATE)),
        .wr_idx(io_addr[1:0]),
        .wdata(io_wdata),
        .pin_in(pin_in[g]),
        .pin_out_r(pin_out[g]),
        .pin_oe_r(pin_oe[g]),
        .rd_val(rd_val[g])
      );
      // port sampled every clock; any bit that moved marks its port
      for (p = 0; p < `DBGC_NPORT; p++) begin : gen_port
        assign port_chg[g*`DBGC_NPORT+p] =
          |(pin_in[g][p*`DBGC_PORT_W +: `DBGC_PORT_W]
            ^ prev_r[g][p*`DBGC_PORT_W +: `DBGC_PORT_W]);
      end
      assign pc3_rise[g] = pin_in[g][`DBGC_PC3_LINE] && !prev_r[g][`DBGC_PC3_LINE];
      assign prev_nxt[g] = pin_in[g];
    end
  endgenerate

  // interrupt sources and the latch
  always_comb begin
    cosen_acc = (io_wr || io_rd) && (wr_acc == ACC_COSEN);
    clr_wr = io_wr && (wr_acc == ACC_CLR);
    cos_mask_nxt = cos_mask_r;
    if (io_wr && (wr_acc == ACC_COSEN)) begin
      cos_mask_nxt = io_wdata[`DBGC_COS_W-1:0];
    end
    user_en_nxt = user_en_r || cosen_acc;
    cos_hit = port_chg & ~cos_mask_r;
    user_hit = user_en_r && (|pc3_rise);
    // a new event in the clearing cycle keeps the latch set
    irq_nxt = (irq_r && !clr_wr) || (|cos_hit) || user_hit;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cos_mask_r <= `DBGC_RST_MASK;
      user_en_r <= 1'b0;
      irq_r <= 1'b0;
      prev_r[0] <= `DBGC_RST_LINES;
      prev_r[1] <= `DBGC_RST_LINES;
    end else begin
      cos_mask_r <= cos_mask_nxt;
      user_en_r <= user_en_nxt;
      irq_r <= irq_nxt;
      prev_r[0] <= prev_nxt[0];
      prev_r[1] <= prev_nxt[1];
    end
  end

  // read data: port offsets return lines, write-only offsets read as zero
  always_comb begin
    rdata_nxt = io_rdata_r;
    if (io_rd) begin
      rdata_nxt = (rd_acc == ACC_PORT) ? rd_val[rd_grp] : `DBGC_RST_BYTE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_rdata_r <= `DBGC_RST_BYTE;
    end else begin
      io_rdata_r <= rdata_nxt;
    end
  end

  // helper: change seen on a masked port only
  logic masked_only;
  assign masked_only = (|port_chg) && !(|cos_hit) && !user_hit;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_IRQ_HOLDS: assert property (
    (irq_r && !(io_wr && io_addr == `DBGC_OFF_CLR)) |=> irq_r)
    else $error("interrupt latch dropped without a clear write");
  AST_IRQ_CLEAR: assert property (
    (io_wr && io_addr == `DBGC_OFF_CLR && !(|cos_hit) && !user_hit) |=> !irq_r)
    else $error("write to clear offset did not clear the latch");
  AST_RESET_MASKED: assert property (
    $rose(rst_n) |-> (cos_mask_r == `DBGC_RST_MASK) && !user_en_r && !irq_r)
    else $error("interrupt sources not masked after reset");
  AST_MASK_BLOCKS: assert property (
    (!irq_r && masked_only && !(io_wr && io_addr == `DBGC_OFF_COSEN)) |=> !irq_r)
    else $error("masked port change raised the interrupt");
  AST_COS_SETS: assert property (
    (|(port_chg & ~cos_mask_r)) |=> irq_r)
    else $error("enabled port change did not latch the interrupt");
  AST_COSEN_WRITE: assert property (
    (io_wr && io_addr == `DBGC_OFF_COSEN)
      |=> cos_mask_r == $past(io_wdata[`DBGC_COS_W-1:0]))
    else $error("enable register did not take the written bits");
  AST_USER_UNMASK: assert property (
    ((io_wr || io_rd) && io_addr == `DBGC_OFF_COSEN) |=> user_en_r [*2])
    else $error("access to enable offset did not unmask line three");
  AST_USER_IRQ: assert property (
    (user_en_r && $rose(g1_pin_in[`DBGC_PC3_LINE])) |-> ##1 irq_r)
    else $error("line three rise did not latch the interrupt");
  AST_READ_PORT: assert property (
    (io_rd && io_addr == 4'h0 && !io_wr) |=> io_rdata_r == $past(rd_val[0]))
    else $error("port read did not return line values");
  COV_COS_IRQ: cover property (!irq_r ##1 irq_r ##[1:50] (io_wr && io_addr == `DBGC_OFF_CLR));
  COV_USER_IRQ: cover property (user_en_r && (|pc3_rise));
  COV_SET_WINS: cover property (clr_wr && (|cos_hit));
endmodule : dbgc_top

//--- dv/dbgc_host_model.sv
// host-side bus model issuing byte writes and reads to the glue
`timescale 1ns/100ps
module dbgc_host_model
  import dbgc_pkg::*;
(
  input logic mclk,
  output logic [3:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output dbgc_byte_t io_wdata,
  input dbgc_byte_t io_rdata_r
);
  initial begin
    io_addr = 4'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic wr(input logic [3:0] a, input dbgc_byte_t d);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge mclk);
    #1;
    io_wr = 1'b0;
    // released data shows no stale value
    io_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output dbgc_byte_t d);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge mclk);
    #1;
    d = io_rdata_r;
    io_rd = 1'b0;
  endtask : rd
endmodule : dbgc_host_model

//--- dv/tb_top.sv
// self-checking bench for the digital i/o glue
`timescale 1ns/100ps
module tb_top
  import dbgc_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic tristate_jumper_position;
  logic [3:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic irq_r;
  dbgc_byte_t io_wdata;
  dbgc_byte_t io_rdata_r;
  dbgc_byte_t rv;
  dbgc_lines_t g0_pin_in;
  dbgc_lines_t g1_pin_in;
  dbgc_lines_t g0_pin_out_r;
  dbgc_lines_t g0_pin_oe_r;
  dbgc_lines_t g1_pin_out_r;
  dbgc_lines_t g1_pin_oe_r;
  int err_count;
  int checked;

  dbgc_top i_dut (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
    .tristate_jumper_position(tristate_jumper_position), .g0_pin_in(g0_pin_in),
    .g0_pin_out_r(g0_pin_out_r), .g0_pin_oe_r(g0_pin_oe_r), .g1_pin_in(g1_pin_in),
    .g1_pin_out_r(g1_pin_out_r), .g1_pin_oe_r(g1_pin_oe_r), .irq_r(irq_r));
  dbgc_host_model i_host (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_r(io_rdata_r));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input dbgc_lines_t e, input dbgc_lines_t g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic chkb(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chkb

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // hang guard: the whole run is far shorter than this
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end

  initial begin
    err_count = 0;
    checked = 0;
    rst_n = 1'b0;
    tristate_jumper_position = 1'b1;
    g0_pin_in = 24'h000000;
    g1_pin_in = 24'h000000;
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    chk("g0_oe", 24'h000000, g0_pin_oe_r);
    chk("g1_oe", 24'h000000, g1_pin_oe_r);
    chk("g0_out", 24'h000000, g0_pin_out_r);
    chkb("irq", 1'b0, irq_r);
    i_host.wr(4'h3, 8'h89);
    i_host.wr(4'h0, 8'h5A);
    cyc(2);
    chk("g0_oe", 24'h000000, g0_pin_oe_r);
    i_host.wr(4'h3, 8'h09);
    cyc(2);
    chk("g0_oe", 24'h00FFFF, g0_pin_oe_r);
    chk("g0_out", 24'h00005A, g0_pin_out_r);
    i_host.wr(4'h8, 8'h80);
    cyc(2);
    chk("g0_oe", 24'h000000, g0_pin_oe_r);
    chk("g0_out", 24'h00005A, g0_pin_out_r);
    i_host.wr(4'h8, 8'h00);
    cyc(2);
    chk("g0_oe", 24'h00FFFF, g0_pin_oe_r);
    g0_pin_in = 24'hA50000;
    i_host.wr(4'h3, 8'h89);
    cyc(2);
    chk("g0_oe", 24'h000000, g0_pin_oe_r);
    chk("g0_out", 24'h000000, g0_pin_out_r);
    i_host.rd(4'h2, rv);
    chk("rd_port_c", 24'h0000A5, {16'h0000, rv});
    i_host.rd(4'hA, rv);
    chk("rd_unmapped", 24'h000000, {16'h0000, rv});
    tristate_jumper_position = 1'b0;
    cyc(2);
    chk("g0_oe", 24'h00FFFF, g0_pin_oe_r);
    tristate_jumper_position = 1'b1;
    i_host.wr(4'h7, 8'h80);
    i_host.wr(4'h4, 8'h3C);
    i_host.wr(4'h9, 8'h00);
    cyc(2);
    chk("g1_oe", 24'hFFFFFF, g1_pin_oe_r);
    i_host.wr(4'h9, 8'h80);
    cyc(2);
    chk("g1_oe", 24'h000000, g1_pin_oe_r);
    chk("g1_out", 24'h00003C, g1_pin_out_r);
    g0_pin_in[0] = 1'b1;
    cyc(3);
    chkb("irq", 1'b0, irq_r);
    i_host.wr(4'hB, 8'h3E);
    cyc(2);
    g0_pin_in[0] = 1'b0;
    cyc(3);
    chkb("irq", 1'b1, irq_r);
    cyc(5);
    chkb("irq", 1'b1, irq_r);
    i_host.wr(4'hF, 8'h5A);
    cyc(1);
    chkb("irq", 1'b0, irq_r);
    g1_pin_in[0] = 1'b1;
    cyc(3);
    chkb("irq", 1'b0, irq_r);
    g1_pin_in[19] = 1'b1;
    cyc(3);
    chkb("irq", 1'b1, irq_r);
    i_host.wr(4'hF, 8'h00);
    cyc(1);
    chkb("irq", 1'b0, irq_r);
    // second reset in mid-run, then a read alone must unmask line three
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    chkb("irq", 1'b0, irq_r);
    chk("g1_oe", 24'h000000, g1_pin_oe_r);
    cyc(2);
    chkb("irq", 1'b0, irq_r);
    i_host.rd(4'hB, rv);
    chk("rd_cosen", 24'h000000, {16'h0000, rv});
    g0_pin_in[19] = 1'b1;
    cyc(3);
    chkb("irq", 1'b1, irq_r);
    report_and_stop();
  end
endmodule : tb_top
